//--- hw/pbpid_regs.sv
// Port B register bank: interrupt enables, PID mask, buffer map and routing path
//
// What this block does
// - Enabled insertion-done status raises the port summary interrupt; disabled it is ignored.
// - Enabled transmit-overrun status raises the summary interrupt; disabled it is ignored.
// - Reserved bits of enables and buffer map ignore writes, read zero.
// - Mask bits set to one take part in the PID compare.
// - An all-zero mask compares nothing and passes every PID.
// - The lowest matching slot routes data to the buffer named by its map field.
// - Slot n map field sits at bits 4n+2:4n; bit 4n+3 reserved.
// - Enables, mask and all slot map fields reset to zero.
// - Insertion-done sets on packet placed while insertion is enabled; insertion then disables until re-enabled.
// - Transmit-overrun sets when the input buffer overflows and data is lost.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module pbpid_regs #(
  parameter int FIFO_DEPTH = pbpid_pkg::FIFO_DEPTH
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     in_valid,
  input  wire pbpid_pkg::pbpid_in_t     in_word,
  output logic                          in_ready,
  input  wire logic                     insert_placed,
  output logic                          insert_enable,
  output logic                          out_valid,
  output pbpid_pkg::pbpid_word_t        out_word,
  input  wire logic                     out_ready,
  output logic                          port_b_summary_interrupt
);

  localparam int WORD_W = $bits(pbpid_pkg::pbpid_word_t);

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("pbpid_regs: FIFO_DEPTH must be at least 2");
  end

  pbpid_pkg::pbpid_regs_t   st;
  pbpid_pkg::pbpid_regs_t   next_st;
  pbpid_pkg::pbpid_filter_t filter_cfg;
  pbpid_pkg::pbpid_word_t   route_word;
  logic                     route_pass;
  logic [2:0]               route_buffer;
  logic                     fifo_in_valid;
  logic                     fifo_in_ready;
  logic [WORD_W-1:0]        fifo_out_data;
  logic                     setup_phase;
  logic                     access_phase;
  logic [31:0]              hw_set;

  function automatic logic is_slot(input logic [11:0] addr);
    is_slot = (addr >= pbpid_pkg::ADDR_SLOT_BASE) &&
              (addr <= pbpid_pkg::ADDR_SLOT_LAST) &&
              (addr[1:0] == 2'h0);
  endfunction : is_slot

  function automatic logic [2:0] slot_index(input logic [11:0] addr);
    logic [11:0] rel;
    rel        = addr - pbpid_pkg::ADDR_SLOT_BASE;
    slot_index = rel[4:2];
  endfunction : slot_index

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (addr == pbpid_pkg::ADDR_STATUS) ||
                (addr == pbpid_pkg::ADDR_INT_EN) ||
                (addr == pbpid_pkg::ADDR_MASK)   ||
                (addr == pbpid_pkg::ADDR_MAP)    ||
                (addr == pbpid_pkg::ADDR_CTRL)   ||
                is_slot(addr);
  endfunction : is_mapped

  function automatic logic [31:0] read_value(input pbpid_pkg::pbpid_regs_t s,
                                             input logic [11:0]            addr);
    read_value = 32'h0000_0000;
    if (is_slot(addr)) begin
      read_value = s.slot_pid[slot_index(addr)];
    end else begin
      case (addr)
        pbpid_pkg::ADDR_STATUS: read_value = s.status;
        pbpid_pkg::ADDR_INT_EN: read_value = s.int_en & pbpid_pkg::INT_WMASK;
        pbpid_pkg::ADDR_MASK:   read_value = s.mask;
        pbpid_pkg::ADDR_MAP:    read_value = s.map & pbpid_pkg::MAP_WMASK;
        pbpid_pkg::ADDR_CTRL:   read_value = s.ctrl & pbpid_pkg::CTRL_WMASK;
        default:                read_value = 32'h0000_0000;
      endcase
    end
  endfunction : read_value

  // Zero wait states; read data is captured in the setup cycle
  assign pready       = 1'b1;
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign pslverr      = access_phase & ~is_mapped(paddr);
  assign prdata       = st.prdata;

  assign insert_enable = st.ctrl[pbpid_pkg::CTRL_INSERT_BIT];

  assign port_b_summary_interrupt =
    (st.status[pbpid_pkg::INT_DONE_BIT] & st.int_en[pbpid_pkg::INT_DONE_BIT]) |
    (st.status[pbpid_pkg::INT_OVERRUN_BIT] & st.int_en[pbpid_pkg::INT_OVERRUN_BIT]);

  assign filter_cfg.filter_en = st.ctrl[pbpid_pkg::CTRL_FILTER_BIT];
  assign filter_cfg.mask      = st.mask;
  assign filter_cfg.map       = st.map;
  assign filter_cfg.slot_pid  = st.slot_pid;

  pbpid_match #(
    .SLOTS (pbpid_pkg::SLOTS)
  ) u_match (
    .pid    (in_word.pid),
    .cfg    (filter_cfg),
    .pass   (route_pass),
    .buffer (route_buffer)
  );

  assign route_word.buffer = route_buffer;
  assign route_word.data   = in_word.data;
  // Words that match no slot are dropped once the FIFO takes input
  assign fifo_in_valid     = in_valid & route_pass;
  assign in_ready          = fifo_in_ready;

  pbpid_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (fifo_in_valid),
    .in_data   (route_word),
    .in_ready  (fifo_in_ready),
    .out_valid (out_valid),
    .out_data  (fifo_out_data),
    .out_ready (out_ready)
  );

  assign out_word = pbpid_pkg::pbpid_word_t'(fifo_out_data);

  always_comb begin
    next_st = st;
    hw_set  = 32'h0000_0000;

    // Hardware events
    hw_set[pbpid_pkg::INT_DONE_BIT]    = insert_placed & st.ctrl[pbpid_pkg::CTRL_INSERT_BIT];
    hw_set[pbpid_pkg::INT_OVERRUN_BIT] = in_valid & ~fifo_in_ready;

    // Insertion disables itself after placing a packet
    if (insert_placed) begin
      next_st.ctrl[pbpid_pkg::CTRL_INSERT_BIT] = 1'b0;
    end

    // Setup phase: capture read data and which status bits it returns
    next_st.rd_clear = 32'h0000_0000;
    if (setup_phase && !pwrite) begin
      next_st.prdata = read_value(st, paddr);
      if (paddr == pbpid_pkg::ADDR_STATUS) begin
        next_st.rd_clear = st.status;
      end
    end

    // Status clears only bits already returned; a new event wins
    next_st.status = st.status;
    if (access_phase && !pwrite) begin
      next_st.status = st.status & ~st.rd_clear;
    end
    next_st.status = next_st.status | hw_set;

    // Access phase writes
    if (access_phase && pwrite) begin
      if (is_slot(paddr)) begin
        next_st.slot_pid[slot_index(paddr)] = pwdata;
      end else begin
        case (paddr)
          pbpid_pkg::ADDR_INT_EN: next_st.int_en = pwdata & pbpid_pkg::INT_WMASK;
          pbpid_pkg::ADDR_MASK:   next_st.mask   = pwdata;
          pbpid_pkg::ADDR_MAP:    next_st.map    = pwdata & pbpid_pkg::MAP_WMASK;
          // Software re-enable overrides a same-cycle self-disable
          pbpid_pkg::ADDR_CTRL:   next_st.ctrl   = pwdata & pbpid_pkg::CTRL_WMASK;
          default:                next_st.ctrl   = next_st.ctrl;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.int_en   <= pbpid_pkg::RST_INT_EN;
      st.mask     <= pbpid_pkg::RST_MASK;
      st.map      <= pbpid_pkg::RST_MAP;
      st.status   <= pbpid_pkg::RST_STATUS;
      st.ctrl     <= pbpid_pkg::RST_CTRL;
      st.slot_pid <= {pbpid_pkg::SLOTS{pbpid_pkg::RST_SLOT}};
      st.prdata   <= 32'h0000_0000;
      st.rd_clear <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

endmodule : pbpid_regs

//--- hw/pbpid_pkg.sv
// Package: register map, field layout, reset values and carrier types
package pbpid_pkg;

  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam int          SLOTS           = 8;
  localparam int          MAP_FIELD_W     = 3;
  localparam int          MAP_GROUP_W     = 4;

  localparam logic [11:0] ADDR_STATUS     = 12'h0C8;
  localparam logic [11:0] ADDR_INT_EN     = 12'h0CC;
  localparam logic [11:0] ADDR_MASK       = 12'h0D0;
  localparam logic [11:0] ADDR_MAP        = 12'h0D4;
  localparam logic [11:0] ADDR_CTRL       = 12'h100;
  localparam logic [11:0] ADDR_SLOT_BASE  = 12'h104;
  localparam logic [11:0] ADDR_SLOT_LAST  = 12'h120;

  localparam int          INT_OVERRUN_BIT = 0;
  localparam int          INT_DONE_BIT    = 8;
  localparam logic [31:0] INT_WMASK       = 32'h0000_0101;
  localparam logic [31:0] MAP_WMASK       = 32'h7777_7777;

  localparam int          CTRL_FILTER_BIT = 0;
  localparam int          CTRL_INSERT_BIT = 1;
  localparam logic [31:0] CTRL_WMASK      = 32'h0000_0003;

  localparam logic [31:0] RST_INT_EN      = 32'h0000_0000;
  localparam logic [31:0] RST_MASK        = 32'h0000_0000;
  localparam logic [31:0] RST_MAP         = 32'h0000_0000;
  localparam logic [31:0] RST_STATUS      = 32'h0000_0000;
  localparam logic [31:0] RST_CTRL        = 32'h0000_0000;
  localparam logic [31:0] RST_SLOT        = 32'h0000_0000;

  localparam int          FIFO_DEPTH      = 16;

  // One routed stream word
  typedef struct packed {
    logic [2:0]  buffer;
    logic [31:0] data;
  } pbpid_word_t;

  // Incoming stream word with its packet identifier
  typedef struct packed {
    logic [31:0] pid;
    logic [31:0] data;
  } pbpid_in_t;

  // Filter setup shared by the register file and the matcher
  typedef struct packed {
    logic             filter_en;
    logic [31:0]      mask;
    logic [31:0]      map;
    logic [7:0][31:0] slot_pid;
  } pbpid_filter_t;

  // Register file state
  typedef struct packed {
    logic [31:0]      int_en;
    logic [31:0]      mask;
    logic [31:0]      map;
    logic [31:0]      status;
    logic [31:0]      ctrl;
    logic [7:0][31:0] slot_pid;
    logic [31:0]      prdata;
    logic [31:0]      rd_clear;
  } pbpid_regs_t;

endpackage : pbpid_pkg

//--- hw/pbpid_fifo.sv
// Stream FIFO with a registered output stage
`timescale 1ns/1ps
module pbpid_fifo #(
  parameter int WIDTH = 35,
  parameter int DEPTH = pbpid_pkg::FIFO_DEPTH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("pbpid_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [AW-1:0]    wr;
    logic [AW-1:0]    rd;
    logic [AW:0]      count;
    logic             out_valid;
    logic [WIDTH-1:0] out_data;
  } pbpid_fifo_state_t;

  localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);

  pbpid_fifo_state_t st;
  pbpid_fifo_state_t next_st;
  logic [WIDTH-1:0]  mem [DEPTH];
  logic              push;
  logic              load;

  assign in_ready  = (st.count != FULL_COUNT);
  assign out_valid = st.out_valid;
  assign out_data  = st.out_data;

  always_comb begin
    next_st = st;
    push    = in_valid & in_ready;
    // Refill the output stage as soon as it drains
    load    = (st.count != '0) & (~st.out_valid | out_ready);
    if (push) begin
      next_st.wr = st.wr + 1'b1;
    end
    if (load) begin
      next_st.rd        = st.rd + 1'b1;
      next_st.out_valid = 1'b1;
      next_st.out_data  = mem[st.rd];
    end else if (out_ready) begin
      next_st.out_valid = 1'b0;
    end
    case ({push, load})
      2'b10:   next_st.count = st.count + 1'b1;
      2'b01:   next_st.count = st.count - 1'b1;
      default: next_st.count = st.count;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset; only words already written are ever read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[st.wr] <= in_data;
    end
  end

endmodule : pbpid_fifo

//--- hw/pbpid_match.sv
// Masked PID compare over the filter slots and buffer selection
`timescale 1ns/1ps
module pbpid_match #(
  parameter int SLOTS = pbpid_pkg::SLOTS
) (
  input  wire logic                    [31:0] pid,
  input  wire pbpid_pkg::pbpid_filter_t       cfg,
  output logic                                pass,
  output logic                         [2:0]  buffer
);

  if (SLOTS < 1 || SLOTS > 8) begin : g_chk
    $error("pbpid_match: SLOTS must lie between 1 and 8");
  end

  function automatic logic slot_match(input logic [31:0] a,
                                      input logic [31:0] b,
                                      input logic [31:0] m);
    slot_match = (((a ^ b) & m) == 32'h0000_0000);
  endfunction : slot_match

  always_comb begin
    pass   = 1'b0;
    buffer = 3'h0;
    if (!cfg.filter_en) begin
      pass = 1'b1;
    end else begin
      // Downward scan so the lowest matching slot wins
      for (int i = SLOTS - 1; i >= 0; i--) begin
        // Zero mask matches every slot, so every PID passes
        if (slot_match(pid, cfg.slot_pid[i], cfg.mask)) begin
          pass   = 1'b1;
          buffer = cfg.map[i*pbpid_pkg::MAP_GROUP_W +: pbpid_pkg::MAP_FIELD_W];
        end
      end
    end
  end

endmodule : pbpid_match

//--- dv/pbpid_regs_asserts.sv
// Checker: bus, stream and interrupt relations at the bank ports
`timescale 1ns/1ps
module pbpid_regs_asserts (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [11:0]            paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   in_valid,
  input wire pbpid_pkg::pbpid_in_t   in_word,
  input wire logic                   in_ready,
  input wire logic                   insert_placed,
  input wire logic                   insert_enable,
  input wire logic                   out_valid,
  input wire pbpid_pkg::pbpid_word_t out_word,
  input wire logic                   out_ready,
  input wire logic                   port_b_summary_interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc, ctrl_wr, en_wr, stat_rd, mapped, ev;
  assign acc = psel && penable;
  assign ctrl_wr = acc && pwrite && paddr == pbpid_pkg::ADDR_CTRL;
  assign en_wr = acc && pwrite && paddr == pbpid_pkg::ADDR_INT_EN;
  assign stat_rd = acc && !pwrite && paddr == pbpid_pkg::ADDR_STATUS;
  assign mapped = paddr[1:0] == 2'h0 && (paddr inside
    {[pbpid_pkg::ADDR_STATUS:pbpid_pkg::ADDR_MAP], [pbpid_pkg::ADDR_CTRL:pbpid_pkg::ADDR_SLOT_LAST]});
  // Any cause that may raise the summary one cycle later
  assign ev = insert_placed && insert_enable || in_valid && !in_ready || en_wr;
  sequence s_rd(logic [11:0] a);
    psel && !penable && !pwrite && paddr == a ##1 acc;
  endsequence
  sequence s_placed;
    insert_placed && insert_enable && !ctrl_wr;
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  chk_err_quiet: assert property (!(acc && !mapped) |-> !pslverr) else $error("stray pslverr");
  chk_out_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
    else $error("stalled output word changed");
  chk_insert_stops: assert property (s_placed |=> !insert_enable)
    else $error("insertion still enabled after placement");
  chk_insert_cause: assert property ($rose(insert_enable) |-> $past(ctrl_wr && pwdata[1]))
    else $error("insertion enabled without software");
  chk_sum_rise: assert property ($rose(port_b_summary_interrupt) |-> $past(ev))
    else $error("summary rose without cause");
  chk_sum_fall: assert property ($fell(port_b_summary_interrupt) |-> $past(stat_rd || en_wr))
    else $error("summary fell without clear");
  chk_int_rsvd: assert property (s_rd(pbpid_pkg::ADDR_INT_EN) |-> (prdata & ~pbpid_pkg::INT_WMASK) == 32'h0)
    else $error("enable reserved bits set");
  chk_map_rsvd: assert property (s_rd(pbpid_pkg::ADDR_MAP) |-> (prdata & ~pbpid_pkg::MAP_WMASK) == 32'h0)
    else $error("map reserved bits set");
endmodule : pbpid_regs_asserts

//--- dv/pbpid_stream_model.sv
// Far side model: stream source, stalling sink, insertion hardware
`timescale 1ns/1ps
module pbpid_stream_model (
  input  wire logic                   pclk,
  input  wire logic                   stall,
  input  wire logic                   in_ready,
  input  wire logic                   out_valid,
  input  wire pbpid_pkg::pbpid_word_t out_word,
  output logic                        in_valid,
  output pbpid_pkg::pbpid_in_t        in_word,
  output logic                        insert_placed,
  output logic                        out_ready
);
  pbpid_pkg::pbpid_word_t got[$];
  initial begin
    in_valid = 1'b0;
    in_word = '0;
    insert_placed = 1'b0;
  end
  assign out_ready = !stall;
  always @(posedge pclk) begin
    if (out_valid === 1'b1 && out_ready) got.push_back(out_word);
  end
  // One word; once=1 ignores ready to overrun on purpose
  task automatic send(input logic [31:0] pid, input logic [31:0] d, input logic once);
    in_valid <= 1'b1;
    in_word <= {pid, d};
    do @(posedge pclk); while (!once && in_ready !== 1'b1);
  endtask : send
  // Released bus shows inverted data, not a stale copy
  task automatic idle;
    in_valid <= 1'b0;
    in_word <= ~in_word;
    @(posedge pclk);
  endtask : idle
  task automatic place;
    insert_placed <= 1'b1;
    @(posedge pclk);
    insert_placed <= 1'b0;
    @(posedge pclk);
  endtask : place
endmodule : pbpid_stream_model

//--- dv/pbpid_regs_bench.sv
// Bench: registers, routing, overrun and insertion of the port B bank
`timescale 1ns/1ps
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin n_mismatch++; \
  $display("ERROR %0t: got %0h exp %0h", $time, (g), (x)); end end
module pbpid_regs_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stall = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic        pready, pslverr, in_valid, in_ready, insert_placed, insert_enable;
  logic        out_valid, out_ready, sum, e;
  pbpid_pkg::pbpid_in_t   in_word;
  pbpid_pkg::pbpid_word_t out_word;
  int          n_mismatch = 0, comparisons = 0, i;
  always #2.5 pclk = ~pclk;
  pbpid_regs pbpid_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_word(in_word), .in_ready(in_ready),
    .insert_placed(insert_placed), .insert_enable(insert_enable), .out_valid(out_valid),
    .out_word(out_word), .out_ready(out_ready), .port_b_summary_interrupt(sum));
  pbpid_stream_model m (.pclk(pclk), .stall(stall), .in_ready(in_ready), .out_valid(out_valid),
    .out_word(out_word), .in_valid(in_valid), .in_word(in_word),
    .insert_placed(insert_placed), .out_ready(out_ready));
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(q, x)
  endtask : rd
  task automatic take(input logic [2:0] b, input logic [31:0] d);
    for (int k = 0; k < 50 && m.got.size() == 0; k++) @(posedge pclk);
    `CHK(m.got.pop_front(), {b, d})
  endtask : take
  task automatic summarize;
    if (n_mismatch == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({in_ready, out_valid, insert_enable, sum}, 4'h8)
    for (i = 0; i < 4; i++) rd(pbpid_pkg::ADDR_STATUS + 12'(4 * i), 32'h0);
    rd(pbpid_pkg::ADDR_CTRL, 32'h0);
    apb(1'b1, pbpid_pkg::ADDR_INT_EN, 32'hFFFF_FFFF);
    rd(pbpid_pkg::ADDR_INT_EN, 32'h0000_0101);
    apb(1'b1, pbpid_pkg::ADDR_MAP, 32'hFFFF_FFFF);
    rd(pbpid_pkg::ADDR_MAP, 32'h7777_7777);
    apb(1'b0, 12'h0D8, 32'h0);
    `CHK({e, q}, {1'b1, 32'h0})
    apb(1'b1, 12'h0CE, 32'h0);
    `CHK(e, 1'b1)
    rd(pbpid_pkg::ADDR_INT_EN, 32'h0000_0101);
    apb(1'b1, pbpid_pkg::ADDR_INT_EN, 32'h0);
    for (i = 0; i < 8; i++) apb(1'b1, pbpid_pkg::ADDR_SLOT_BASE + 12'(4 * i), 32'h100 + i);
    apb(1'b1, pbpid_pkg::ADDR_MAP, 32'h0123_4567);
    apb(1'b1, pbpid_pkg::ADDR_MASK, 32'hFFFF_FFFF);
    apb(1'b1, pbpid_pkg::ADDR_CTRL, 32'h1);
    // No slot holds this PID, so it must vanish
    m.send(32'h1FF, 32'hBAD, 1'b0);
    for (i = 0; i < 8; i++) m.send(32'h100 + i, i, 1'b0);
    m.idle();
    for (i = 0; i < 8; i++) take(3'(7 - i), i);
    apb(1'b1, pbpid_pkg::ADDR_MASK, 32'h0000_000F);
    m.send(32'h0000_ABC5, 32'h55, 1'b0);
    m.idle();
    take(3'h2, 32'h55);
    apb(1'b1, pbpid_pkg::ADDR_MASK, 32'h0);
    m.send(32'h0000_DEAD, 32'h66, 1'b0);
    m.idle();
    take(3'h7, 32'h66);
    apb(1'b1, pbpid_pkg::ADDR_CTRL, 32'h0);
    stall <= 1'b1;
    for (i = 0; i < 18; i++) m.send(32'h0, i, 1'b1);
    m.idle();
    `CHK(sum, 1'b0)
    rd(pbpid_pkg::ADDR_STATUS, 32'h1);
    rd(pbpid_pkg::ADDR_STATUS, 32'h0);
    apb(1'b1, pbpid_pkg::ADDR_INT_EN, 32'h1);
    m.send(32'h0, 32'h99, 1'b1);
    m.idle();
    `CHK(sum, 1'b1)
    rd(pbpid_pkg::ADDR_STATUS, 32'h1);
    `CHK(sum, 1'b0)
    stall <= 1'b0;
    for (i = 0; i < 17; i++) take(3'h0, i);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, pbpid_pkg::ADDR_INT_EN, i[0] ? 32'h100 : 32'h0);
      apb(1'b1, pbpid_pkg::ADDR_CTRL, 32'h2);
      `CHK(insert_enable, 1'b1)
      m.place();
      `CHK({insert_enable, sum}, {1'b0, i[0]})
      rd(pbpid_pkg::ADDR_STATUS, 32'h100);
    end
    // Placement while insertion is off must not raise the status
    m.place();
    `CHK({insert_enable, sum}, 2'h0)
    rd(pbpid_pkg::ADDR_STATUS, 32'h0);
    summarize();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
endmodule : pbpid_regs_bench
bind pbpid_regs pbpid_regs_asserts chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_word(in_word),
  .in_ready(in_ready), .insert_placed(insert_placed), .insert_enable(insert_enable),
  .out_valid(out_valid), .out_word(out_word), .out_ready(out_ready),
  .port_b_summary_interrupt(port_b_summary_interrupt));
